// ---- logic/usd_pkg.sv ----
// Package for the upper segment and debug segment decoder.
// Assumes a 32-bit virtual address and one core clock.
package usd_pkg;

  localparam logic [2:0]  KSP2_TOP      = 3'h6;
  localparam logic [2:0]  KSP3_TOP      = 3'h7;
  localparam logic [10:0] DSEG_TOP      = 11'h7F9;
  localparam logic [31:0] DMSEG_BASE    = 32'hFF20_0000;
  localparam logic [31:0] DRSEG_BASE    = 32'hFF30_0000;
  localparam logic [19:0] SUB_OFS_MASK  = 20'hF_FFFF;
  localparam logic [1:0]  SIZE_WORD     = 2'h2;
  localparam int          ADDR_W        = 32;
  localparam int          OFS_W         = 20;

  typedef enum logic [1:0] {
    USD_TR_FETCH = 2'h0,
    USD_TR_LOAD  = 2'h1,
    USD_TR_STORE = 2'h2
  } usd_trans_e;

  typedef enum logic [2:0] {
    USD_RT_NONE  = 3'h0,
    USD_RT_KSP2  = 3'h1,
    USD_RT_KSP3  = 3'h2,
    USD_RT_PROBE = 3'h3,
    USD_RT_DREG  = 3'h4,
    USD_RT_OTHER = 3'h5
  } usd_route_e;

  typedef struct packed {
    logic       user_mode_bit;
    logic       exception_level_bit;
    logic       error_level_bit;
    logic       debug_mode_bit;
    logic       load_store_normal_memory_bit;
    logic       probe_enable_bit;
  } usd_mode_s;

  typedef struct packed {
    logic        valid;
    usd_trans_e  trans;
    logic [1:0]  size;
    logic [31:0] vaddr;
    logic [31:0] wdata;
  } usd_req_s;

  typedef struct packed {
    usd_route_e  route;
    logic [31:0] paddr;
    logic        translate;
    logic        uncached;
    logic        kernel;
  } usd_dec_s;

  typedef enum logic [1:0] {
    USD_ST_IDLE  = 2'h0,
    USD_ST_PROBE = 2'h1,
    USD_ST_DONE  = 2'h2
  } usd_state_e;

endpackage

// ---- logic/usd_decoder.sv ----
// Upper kernel segment and debug segment decoder.
// Assumes requests are held steady by the pipeline while stall_o is high.
`timescale 1ns/1ns

// Summary of operation
// [R1] Kernel mode: debug bit clear and user bit clear or error or exception.
// [R2] Top bits 110 in kernel mode select kernel space 2.
// [R3] Top bits 111 in kernel mode select kernel space 3.
// [R4] Debug mode decodes as kernel, except debug segment FF20_0000-FF3F_FFFF.
// [R5] Lower debug half goes to probe memory, offsets 0 to F_FFFF.
// [R6] Upper debug half goes to debug registers, offsets 0 to F_FFFF.
// [R7] In debug mode a would-be exception becomes a debug-mode exception.
// [R8] Kernel spaces 0 and 1 stay reachable in debug mode.
// [R9] Debug-register range: normal-memory loads/stores go to kernel space 3.
// [R10] Unimplemented debug registers read unspecified, ignore writes.
// [R11] Only word accesses to debug registers are supported.
// [R12] Probe range: normal-memory loads/stores to kernel space 3, else probe.
// [R13] Probe access with probe enable clear still goes out and stalls.
// [R14] The probe must serve requests even after clearing probe enable.
// [R15] Kernel space 3 outside the debug segment decodes as ordinary.
module usd_decoder
  import usd_pkg::*;
#(
  parameter int NUM_DREG = 4
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // Mode bits
  input  wire usd_mode_s   mode_i,
  // Pipeline request
  input  wire usd_req_s    req_i,
  input  wire logic        tlb_fault_i,
  output logic             stall_o,
  output logic             done_o,
  output logic [31:0]      rdata_o,
  output usd_dec_s         dec_o,
  output logic             addr_err_o,
  output logic             gen_exc_o,
  output logic             dbg_exc_o,
  // Probe memory side
  output logic             probe_req_o,
  output logic             probe_wr_o,
  output logic [OFS_W-1:0] probe_ofs_o,
  output logic [31:0]      probe_wdata_o,
  input  wire logic        probe_ack_i,
  input  wire logic [31:0] probe_rdata_i,
  // Debug register file contents
  output logic             dreg_undef_o,
  output logic [NUM_DREG*32-1:0] dreg_o
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the probe acknowledge
  logic ack_s1_reg;
  logic ack_s2_reg;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      ack_s1_reg <= probe_ack_i;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Combinational decode
  logic       kernel;
  logic       dbg;
  logic       top_kern;
  logic       in_dseg;
  logic       in_probe;
  logic       nrm_ls;
  usd_dec_s   dec;
  logic       fault;

  // Mode and window qualifiers
  always_comb begin
    dbg      = mode_i.debug_mode_bit;

    kernel   = !dbg && (!mode_i.user_mode_bit ||
               mode_i.error_level_bit ||
               mode_i.exception_level_bit);                         // [R1]

    // Debug mode sees the kernel map
    top_kern = kernel || dbg;

    in_dseg  = dbg && (req_i.vaddr[31:21] == DSEG_TOP);             // [R4]
    in_probe = !req_i.vaddr[20];

    // Normal-memory bit only redirects loads and stores
    nrm_ls   = mode_i.load_store_normal_memory_bit &&
               (req_i.trans != USD_TR_FETCH);
  end

  ////////////////////////////////////////////////////////////////////////
  // Segment routing
  always_comb begin
    dec           = '0;
    dec.route     = USD_RT_OTHER;
    dec.kernel    = top_kern;
    dec.paddr     = req_i.vaddr;

    if (top_kern) begin
      unique case (req_i.vaddr[31:29])
        KSP2_TOP: begin
          dec.route     = USD_RT_KSP2;                              // [R2]
          dec.translate = 1'b1;
        end

        KSP3_TOP: begin
          dec.route     = USD_RT_KSP3;                              // [R3] [R15]
          dec.translate = 1'b1;

          if (in_dseg && !nrm_ls) begin                             // [R9] [R12]
            dec.translate = 1'b0;
            dec.uncached  = 1'b1;
            dec.route     = in_probe ? USD_RT_PROBE : USD_RT_DREG;  // [R5] [R6]
            dec.paddr     = {12'h000, req_i.vaddr[19:0] & SUB_OFS_MASK};
          end
        end

        default: begin
          dec.route = USD_RT_OTHER;                                 // [R8]
        end
      endcase

    end else if (req_i.vaddr[31]) begin
      // Upper half is out of reach in user mode
      dec.route = USD_RT_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Translation faults only apply to mapped routes
  always_comb begin
    fault = tlb_fault_i && dec.translate;
  end

  ////////////////////////////////////////////////////////////////////////
  // Probe transfer state
  usd_state_e          state_reg;
  usd_state_e          state_next;
  logic [31:0]         rdata_reg;
  logic [31:0]         rdata_next;
  logic                done_reg;
  logic                done_next;
  logic                probe_go;
  logic                dreg_go;
  logic [31:0]         dreg_rd;

  // Access starts
  assign probe_go = req_i.valid && (dec.route == USD_RT_PROBE);
  assign dreg_go  = req_i.valid && (dec.route == USD_RT_DREG);


  // Probe enable only informs software; the request goes out regardless
  always_comb begin
    state_next = state_reg;
    rdata_next = rdata_reg;
    done_next  = 1'b0;
    unique case (state_reg)
      USD_ST_IDLE: begin
        if (probe_go) begin
          state_next = USD_ST_PROBE;                                // [R13]
        end
      end
      USD_ST_PROBE: begin
        if (ack_s2_reg) begin                                       // [R14]
          rdata_next = probe_rdata_i;
          done_next  = 1'b1;
          state_next = USD_ST_DONE;
        end
      end
      USD_ST_DONE: begin
        if (!ack_s2_reg) begin
          state_next = USD_ST_IDLE;
        end
      end
      default: begin
        state_next = USD_ST_IDLE;
      end
    endcase

    // Debug registers answer in one cycle
    if (dreg_go) begin
      rdata_next = dreg_rd;
      done_next  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_reg <= USD_ST_IDLE;
      rdata_reg <= 32'h0000_0000;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      rdata_reg <= rdata_next;
      done_reg  <= done_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Debug register file
  localparam int DIDX_W = (NUM_DREG > 1) ? $clog2(NUM_DREG) : 1;
  logic [31:0]       dreg_mem [NUM_DREG];
  logic [31:0]       dreg_nxt [NUM_DREG];
  logic [OFS_W-3:0]  widx;
  logic              impl;
  logic              wr_ok;

  // Word index and write qualification
  always_comb begin
    widx  = dec.paddr[OFS_W-1:2];
    impl  = (widx < (OFS_W-2)'(NUM_DREG));

    // Unimplemented words and non-word sizes never write
    wr_ok = dreg_go && (req_i.trans == USD_TR_STORE) && impl &&
            (req_i.size == SIZE_WORD);                              // [R10] [R11]

    dreg_rd = 32'h0000_0000;
    if (impl) begin
      dreg_rd = dreg_mem[widx[DIDX_W-1:0]];
    end
    for (int i = 0; i < NUM_DREG; i++) begin
      dreg_nxt[i] = dreg_mem[i];
      if (wr_ok && (widx[DIDX_W-1:0] == DIDX_W'(i))) begin
        dreg_nxt[i] = req_i.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < NUM_DREG; i++) begin
      if (srst_i) begin
        dreg_mem[i] <= 32'h0000_0000;
      end else begin
        dreg_mem[i] <= dreg_nxt[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Debug register contents
  always_comb begin
    for (int i = 0; i < NUM_DREG; i++) begin
      dreg_o[i*32 +: 32] = dreg_mem[i];
    end
  end

  assign dreg_undef_o  = dreg_go && (req_i.size != SIZE_WORD);      // [R11]

  ////////////////////////////////////////////////////////////////////////
  // Decode and exception outputs
  assign dec_o         = dec;
  assign addr_err_o    = req_i.valid && (dec.route == USD_RT_NONE);

  // Debug-mode faults bypass the normal handlers
  assign gen_exc_o     = req_i.valid && !dbg && fault;
  assign dbg_exc_o     = req_i.valid && dbg && fault;               // [R7]

  ////////////////////////////////////////////////////////////////////////
  // Probe side outputs
  assign probe_req_o   = (state_reg == USD_ST_PROBE);               // [R5]
  assign probe_wr_o    = probe_req_o && (req_i.trans == USD_TR_STORE);
  assign probe_ofs_o   = dec.paddr[OFS_W-1:0];
  assign probe_wdata_o = req_i.wdata;

  ////////////////////////////////////////////////////////////////////////
  // Pipeline handshake outputs
  assign stall_o       = (probe_go && (state_reg == USD_ST_IDLE)) ||
                         (state_reg == USD_ST_PROBE);               // [R13]
  assign done_o        = done_reg;
  assign rdata_o       = rdata_reg;

endmodule

// ---- dv/usd_probe_model.sv ----
// Behavioural probe serving the probe memory window.
// Answers after lat_i cycles and holds ack until the request drops.
`timescale 1ns/1ns
module usd_probe_model (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // Probe bus
  input  wire logic        req_i,
  input  wire logic        wr_i,
  input  wire logic [19:0] ofs_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  lat_i,
  output logic             ack_o,
  output logic [31:0]      rdata_o
);
  logic [31:0] mem [16];
  logic [3:0]  cnt;
  always @(posedge clk_sys_i) begin
    if (srst_i || !req_i) begin
      cnt <= 4'h0;
      ack_o <= 1'b0;
      rdata_o <= srst_i ? 32'h5A5A_5A5A : ~rdata_o;
    end else if (cnt < lat_i) begin
      cnt <= cnt + 4'h1;
    end else if (!ack_o) begin // Serves whatever the enable bit
      ack_o <= 1'b1;
      rdata_o <= wr_i ? ~rdata_o : mem[ofs_i[5:2]];
      if (wr_i) mem[ofs_i[5:2]] <= wdata_i;
    end
  end
endmodule

// ---- dv/usd_decoder_assertions.sv ----
// Port checks for the upper segment decoder.
// Bound to every usd_decoder instance.
`timescale 1ns/1ns
module usd_decoder_assertions
  import usd_pkg::*;
(
  input wire logic             clk_sys_i,
  input wire logic             srst_i,
  input wire usd_mode_s        mode_i,
  input wire usd_req_s         req_i,
  input wire logic             tlb_fault_i,
  input wire logic             stall_o,
  input wire logic             done_o,
  input wire usd_dec_s         dec_o,
  input wire logic             gen_exc_o,
  input wire logic             dbg_exc_o,
  input wire logic             probe_req_o,
  input wire logic             probe_ack_i,
  input wire logic [OFS_W-1:0] probe_ofs_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  logic dbm, kern, dsp, vl;
  assign vl = req_i.valid;
  assign dbm = mode_i.debug_mode_bit;
  assign kern = !dbm && (!mode_i.user_mode_bit || mode_i.error_level_bit
                || mode_i.exception_level_bit);
  assign dsp = vl && dbm && (req_i.trans == USD_TR_FETCH
               || !mode_i.load_store_normal_memory_bit);
  property p_kern; vl && !dbm |-> dec_o.kernel == kern; endproperty
  a_kern: assert property (p_kern) else $error("kernel");
  property p_ks2; vl && kern && req_i.vaddr[31:29] == KSP2_TOP
    |-> dec_o.route == USD_RT_KSP2; endproperty
  a_ks2: assert property (p_ks2) else $error("ks2");
  property p_ks3; vl && kern && req_i.vaddr[31:29] == KSP3_TOP
    |-> dec_o.route == USD_RT_KSP3; endproperty
  a_ks3: assert property (p_ks3) else $error("ks3");
  property p_prb; dsp && req_i.vaddr[31:20] == 12'hFF2 |->
    dec_o.route == USD_RT_PROBE && probe_ofs_o == req_i.vaddr[19:0]; endproperty
  a_prb: assert property (p_prb) else $error("probe");
  property p_drg; dsp && req_i.vaddr[31:20] == 12'hFF3
    |-> dec_o.route == USD_RT_DREG; endproperty
  a_drg: assert property (p_drg) else $error("dreg");
  property p_nrm; vl && dbm && !dsp && req_i.vaddr[31:21] == DSEG_TOP
    |-> dec_o.route == USD_RT_KSP3; endproperty
  a_nrm: assert property (p_nrm) else $error("normal");
  property p_exc; vl && tlb_fault_i && dec_o.translate
    |-> dbg_exc_o == dbm && gen_exc_o == !dbm; endproperty
  a_exc: assert property (p_exc) else $error("exc");
  property p_stl; $rose(stall_o) |=> probe_req_o && stall_o; endproperty
  a_stl: assert property (p_stl) else $error("stall");
  property p_ack; $rose(probe_ack_i) && probe_req_o |-> ##[1:4] done_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack");
endmodule
bind usd_decoder usd_decoder_assertions chk_u (.*);

// ---- dv/testbench.sv ----
// Self-checking bench for the upper segment decoder.
// Assumes the probe model on the probe side.
`timescale 1ns/1ns
module testbench
  import usd_pkg::*;
;
  logic         clk_sys_i, srst_i, flt, ack, stall, done, aerr, gexc, dexc;
  logic         preq, pwr, undef;
  logic [3:0]   lat;
  logic [19:0]  pofs;
  logic [31:0]  rdata, pwd, prd;
  logic [127:0] dreg;
  usd_mode_s    md;
  usd_req_s     rq;
  usd_dec_s     dec;
  int           miscompares, compares;
  usd_decoder dut_u (.clk_sys_i, .srst_i, .mode_i(md), .req_i(rq),
    .tlb_fault_i(flt), .stall_o(stall), .done_o(done), .rdata_o(rdata),
    .dec_o(dec), .addr_err_o(aerr), .gen_exc_o(gexc), .dbg_exc_o(dexc),
    .probe_req_o(preq), .probe_wr_o(pwr), .probe_ofs_o(pofs),
    .probe_wdata_o(pwd), .probe_ack_i(ack), .probe_rdata_i(prd),
    .dreg_undef_o(undef), .dreg_o(dreg));
  usd_probe_model prb_u (.clk_sys_i, .srst_i, .req_i(preq), .wr_i(pwr),
    .ofs_i(pofs), .wdata_i(pwd), .lat_i(lat), .ack_o(ack), .rdata_o(prd));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string n, input logic [127:0] s, e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic acc(input usd_trans_e t, input logic [1:0] sz,
                     input logic [31:0] a, d, input usd_route_e r);
    logic f;
    f = flt && (r inside {USD_RT_KSP2, USD_RT_KSP3});
    rq = '{1'b1, t, sz, a, d};
    #1 chk("route", dec.route, r);
    chk("aerr", aerr, r == USD_RT_NONE);
    chk("exc", {dexc, gexc}, {md[2] & f, ~md[2] & f});
    chk("undef", undef, r == USD_RT_DREG && sz != SIZE_WORD);
    if (r == USD_RT_PROBE) chk("pofs", {stall, pofs}, {1'b1, a[19:0]});
    @(negedge clk_sys_i);
    for (int i = 0; i < 60 && r inside {USD_RT_PROBE, USD_RT_DREG}
         && done !== 1'b1; i++) @(negedge clk_sys_i);
    rq.valid = 1'b0;
    repeat (6) @(negedge clk_sys_i);
  endtask
  task automatic t_kernel;
    logic [5:0] m [3] = '{6'h00, 6'h30, 6'h28};
    flt = 1'b1;
    foreach (m[i]) begin
      md = m[i];
      acc(USD_TR_LOAD, SIZE_WORD, 32'hC000_0100, 0, USD_RT_KSP2);
      acc(USD_TR_FETCH, SIZE_WORD, 32'hFF20_0000, 0, USD_RT_KSP3);
    end
    md = 6'h20;
    acc(USD_TR_LOAD, SIZE_WORD, 32'hC000_0000, 0, USD_RT_NONE);
    $display("t_kernel done");
  endtask
  task automatic t_debug;
    md = 6'h04;
    acc(USD_TR_LOAD, SIZE_WORD, 32'hFF10_0000, 0, USD_RT_KSP3);
    acc(USD_TR_FETCH, SIZE_WORD, 32'h8000_0000, 0, USD_RT_OTHER);
    flt = 1'b0;
    md = 6'h06;
    acc(USD_TR_STORE, SIZE_WORD, 32'hFF30_0000, 1, USD_RT_KSP3);
    acc(USD_TR_LOAD, SIZE_WORD, 32'hFF2F_FFFC, 0, USD_RT_KSP3);
    $display("t_debug done");
  endtask
  task automatic t_dreg;
    md = 6'h04;
    acc(USD_TR_STORE, SIZE_WORD, 32'hFF30_0004, 32'hA5A5_0001, USD_RT_DREG);
    acc(USD_TR_STORE, 2'h1, 32'hFF30_0008, 32'h1234_5678, USD_RT_DREG);
    acc(USD_TR_STORE, SIZE_WORD, 32'hFF30_0100, 32'hFFFF_FFFF, USD_RT_DREG);
    acc(USD_TR_FETCH, SIZE_WORD, 32'hFF30_0004, 0, USD_RT_DREG);
    chk("rdata", rdata, 32'hA5A5_0001);
    chk("dregs", dreg, {64'h0, 32'hA5A5_0001, 32'h0});
    $display("t_dreg done");
  endtask
  task automatic t_probe;
    lat = 4'h5;
    acc(USD_TR_STORE, SIZE_WORD, 32'hFF20_0010, 32'h0BAD_F00D, USD_RT_PROBE);
    lat = 4'h0;
    md = 6'h05;
    acc(USD_TR_FETCH, SIZE_WORD, 32'hFF2F_FFFC, 0, USD_RT_PROBE);
    acc(USD_TR_LOAD, SIZE_WORD, 32'hFF20_0010, 0, USD_RT_PROBE);
    chk("prdata", rdata, 32'h0BAD_F00D);
    $display("t_probe done");
  endtask
  initial begin
    {srst_i, flt, lat, md, rq, miscompares, compares} = '0;
    srst_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    srst_i = 1'b0;
    t_kernel();
    t_debug();
    t_dreg();
    t_probe();
    results();
  end
  initial begin
    #200000;
    miscompares++;
    results();
  end
endmodule
